//--- core/tmc_params.svh
/*
 * Register offsets, field positions, reset values and code points of the timer module.
 * Included by the package and the core; holds definitions only.
 */
`ifndef TMC_PARAMS_SVH
`define TMC_PARAMS_SVH

`define TMC_OFF_CTRL0     12'h000
`define TMC_OFF_CTRL1     12'h004
`define TMC_OFF_CNT_LO    12'h008
`define TMC_OFF_CNT_HI    12'h00c
`define TMC_OFF_CMPA_LO   12'h010
`define TMC_OFF_CMPA_HI   12'h014
`define TMC_OFF_STATUS    12'h018

`define TMC_CTRL_RESET    8'h00
`define TMC_C0_PAUSE      7
`define TMC_C0_CKSEL_HI   6
`define TMC_C0_CKSEL_LO   4
`define TMC_C0_ENABLE     3
`define TMC_C0_PTOP_HI    2
`define TMC_C0_PTOP_LO    0
`define TMC_C1_MODE_HI    7
`define TMC_C1_MODE_LO    6
`define TMC_C1_PFS_HI     5
`define TMC_C1_PFS_LO     4
`define TMC_C1_INIT       3
`define TMC_C1_POL        2
`define TMC_C1_DPX        1
`define TMC_C1_CCLR       0

`define TMC_CK_SYS_DIV4   3'h0
`define TMC_CK_SYS        3'h1
`define TMC_CK_H_DIV16    3'h2
`define TMC_CK_H_DIV64    3'h3
`define TMC_CK_SUB_A      3'h4
`define TMC_CK_SUB_B      3'h5
`define TMC_CK_EXT_RISE   3'h6
`define TMC_CK_EXT_FALL   3'h7

`define TMC_MODE_CMP      2'h0
`define TMC_MODE_UNDEF    2'h1
`define TMC_MODE_PWM      2'h2
`define TMC_MODE_TIMER    2'h3

`define TMC_PFS_NONE      2'h0
`define TMC_PFS_LOW       2'h1
`define TMC_PFS_HIGH      2'h2
`define TMC_PFS_TOGGLE    2'h3

`define TMC_DIV4_LAST     6'h03
`define TMC_DIV16_LAST    6'h0f
`define TMC_DIV64_LAST    6'h3f

`endif

//--- core/tmc_pkg.sv
/*
 * Types shared by the timer module core.
 * Assumes tmc_params.svh is on the include path.
 */
`include "tmc_params.svh"

package tmc_pkg;

    typedef logic [2:0] tmc_cksel_t;
    typedef logic [1:0] tmc_mode_t;

    typedef enum {
        TMC_BUS_IDLE,
        TMC_BUS_ACCESS
    } tmc_bus_state_t;

endpackage

//--- core/tmc_core.sv
/*
 * Compact timer module: 10-bit up counter, comparators A and P, compare
 * match and PWM output on a true and an inverted pin, event counting on an
 * external clock pin, byte-wide register pairs behind a shared low-byte buffer,
 * reached over APB.
 * Assumes pclk is the system clock, the high and subsidiary clock ticks arrive
 * as asynchronous level inputs, and pin multiplexing is done outside.
 */
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "tmc_params.svh"

// Summary of operation
// - Match raises interrupt, may clear counter, drive pin
// - Counter clock chosen among system, high, sub, pin
// - External pin counts on selected rising or falling
// - Separate interrupt pulses for match A and P
// - Inverted pin always mirrors primary output pin
// - Compare mode: match sets, clears or toggles output
// - PWM drives the same output pin pair
// - Capture edge select: rise, fall or both; the core has no capture logic
// - Pulse trigger shares external clock pin; the core has no pulse trigger
// - Low bytes only through shared buffer on high access
// - Low write fills buffer, high write commits both
// - High read latches low byte into buffer
// - Three modes: compare, timer, PWM
// - Counter and comparator A are ten bits
// - Enable rise clears counter; fall holds it
// - Comparator P checks top three bits; zero overflows
// - Select codes 110 rising, 111 falling pin
// - Mode codes 00 compare, 10 PWM, 11 timer
module tmc_core
    import tmc_pkg::*;
#(
    parameter int CNT_W = 10
)
(
    input  wire logic        pclk,              // System clock, 250 MHz.
    input  wire logic        presetn,           // Asynchronous reset, active low.
    input  wire logic        psel,              // APB select.
    input  wire logic        penable,           // APB access phase.
    input  wire logic        pwrite,            // APB write.
    input  wire logic [11:0] paddr,             // APB byte address.
    input  wire logic [31:0] pwdata,            // APB write data.
    input  wire logic [3:0]  pstrb,             // APB byte strobes.
    output logic      [31:0] prdata,            // APB read data.
    output logic             pready,            // APB ready.
    output logic             pslverr,           // APB error on unmapped address.
    input  wire logic        high_clk_tick,     // Internal high clock, asynchronous.
    input  wire logic        sub_clk_tick,      // Subsidiary clock, asynchronous.
    input  wire logic        ext_clock_pin,     // External count clock pin.
    output logic             timer_out_pin,     // Primary timer output.
    output logic             timer_out_inv_pin, // Inverted timer output.
    output logic             irq_match_a,       // Comparator A match pulse.
    output logic             irq_match_p        // Comparator P match pulse.
);

    localparam int HI_W = CNT_W - 8;

    initial
    begin
        if (CNT_W != 10)
            $error("tmc_core: CNT_W must be 10");
    end

    logic [7:0]       ctrl0;
    logic [7:0]       ctrl1;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] compare_a_value;
    logic [7:0]       lo_buffer;
    logic             enable_q;
    logic [2:0]       ext_sync;
    logic [1:0]       high_sync;
    logic [1:0]       sub_sync;
    logic             high_q;
    logic             sub_q;
    logic [5:0]       div_sys;
    logic [5:0]       div_high;
    logic             out_level;
    logic [7:0]       status;

    logic             counter_enable_bit;
    logic             pause;
    tmc_cksel_t       count_clock_select;
    logic [2:0]       period_top_bits;
    tmc_mode_t        mode_field;
    logic [1:0]       pin_function_select;
    logic             init_level;
    logic             clear_on_a;
    logic             setup;
    logic             access;
    logic             wr_stb;
    logic             rd_stb;
    logic             tick;
    logic             high_edge;
    logic             sub_edge;
    logic             match_a;
    logic             match_p;
    logic             enable_rise;
    logic             clear_cnt;
    logic [CNT_W-1:0] next_count;
    logic             next_out;
    logic [31:0]      next_rdata;
    logic             mapped;

    assign counter_enable_bit  = ctrl0[`TMC_C0_ENABLE];
    assign pause               = ctrl0[`TMC_C0_PAUSE];
    assign count_clock_select  = ctrl0[`TMC_C0_CKSEL_HI:`TMC_C0_CKSEL_LO];
    assign period_top_bits     = ctrl0[`TMC_C0_PTOP_HI:`TMC_C0_PTOP_LO];
    assign mode_field          = ctrl1[`TMC_C1_MODE_HI:`TMC_C1_MODE_LO];
    assign pin_function_select = ctrl1[`TMC_C1_PFS_HI:`TMC_C1_PFS_LO];
    assign init_level          = ctrl1[`TMC_C1_INIT];
    assign clear_on_a          = ctrl1[`TMC_C1_CCLR];

    function automatic logic addr_is(input logic [11:0] a, input logic [11:0] off);
        addr_is = (a == off);
    endfunction

    assign setup  = psel && !penable;
    assign access = psel && penable;
    assign wr_stb = access && pwrite && pstrb[0] && mapped;
    assign rd_stb = access && !pwrite && mapped;
    assign mapped = addr_is(paddr, `TMC_OFF_CTRL0) || addr_is(paddr, `TMC_OFF_CTRL1)
                 || addr_is(paddr, `TMC_OFF_CNT_LO) || addr_is(paddr, `TMC_OFF_CNT_HI)
                 || addr_is(paddr, `TMC_OFF_CMPA_LO) || addr_is(paddr, `TMC_OFF_CMPA_HI)
                 || addr_is(paddr, `TMC_OFF_STATUS);

    // Asynchronous clock sources pass two flops; the third stage is for edges.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ext_sync  <= 3'h0;
            high_sync <= 2'h0;
            sub_sync  <= 2'h0;
            high_q    <= 1'b0;
            sub_q     <= 1'b0;
        end
        else
        begin
            ext_sync  <= {ext_sync[1:0], ext_clock_pin};
            high_sync <= {high_sync[0], high_clk_tick};
            sub_sync  <= {sub_sync[0], sub_clk_tick};
            high_q    <= high_sync[1];
            sub_q     <= sub_sync[1];
        end
    end

    assign high_edge = high_sync[1] && !high_q;
    assign sub_edge  = sub_sync[1] && !sub_q;

    // Prescalers for the divided system and high clocks.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_sys <= 6'h0;
        else if (div_sys == `TMC_DIV4_LAST)
            div_sys <= 6'h0;
        else
            div_sys <= div_sys + 6'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_high <= 6'h0;
        else if (high_edge)
            div_high <= div_high + 6'h1;
    end

    always_comb
    begin
        case (count_clock_select)
            `TMC_CK_SYS_DIV4: tick = (div_sys == `TMC_DIV4_LAST);
            `TMC_CK_SYS:      tick = 1'b1;
            `TMC_CK_H_DIV16:  tick = high_edge && (div_high[3:0] == `TMC_DIV16_LAST);
            `TMC_CK_H_DIV64:  tick = high_edge && (div_high == `TMC_DIV64_LAST);
            `TMC_CK_SUB_A,
            `TMC_CK_SUB_B:    tick = sub_edge;
            `TMC_CK_EXT_RISE: tick = ext_sync[1] && !ext_sync[2];
            `TMC_CK_EXT_FALL: tick = !ext_sync[1] && ext_sync[2];
            default:          tick = 1'b0;
        endcase
    end

    assign enable_rise = counter_enable_bit && !enable_q;
    assign match_a = tick && (count == compare_a_value);
    // The match ends a period of top times 128 ticks; a zero code wraps to full range.
    assign match_p = tick && ((period_top_bits == 3'h0) ? (count == '1)
                   : (count == {period_top_bits - 3'h1, {(CNT_W-3){1'b1}}}));
    assign clear_cnt = clear_on_a ? match_a : match_p;

    always_comb
    begin
        next_count = count;
        if (enable_rise)
            next_count = '0;
        else if (counter_enable_bit && !pause && tick)
        begin
            if (clear_cnt)
                next_count = '0;
            else
                next_count = count + 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            count    <= '0;
            enable_q <= 1'b0;
        end
        else
        begin
            count    <= next_count;
            enable_q <= counter_enable_bit;
        end
    end

    always_comb
    begin
        next_out = out_level;
        if (enable_rise && (mode_field == `TMC_MODE_CMP || mode_field == `TMC_MODE_PWM))
            next_out = init_level;
        else if (counter_enable_bit && !pause)
        begin
            case (mode_field)
                `TMC_MODE_CMP:
                begin
                    if (match_a)
                    begin
                        case (pin_function_select)
                            `TMC_PFS_LOW:    next_out = 1'b0;
                            `TMC_PFS_HIGH:   next_out = 1'b1;
                            `TMC_PFS_TOGGLE: next_out = !out_level;
                            default:         next_out = out_level;
                        endcase
                    end
                end
                `TMC_MODE_PWM:
                begin
                    case (pin_function_select)
                        `TMC_PFS_NONE: next_out = !init_level;
                        `TMC_PFS_LOW:  next_out = init_level;
                        `TMC_PFS_HIGH:
                        begin
                            if (match_p)
                                next_out = init_level;
                            else if (match_a)
                                next_out = !init_level;
                        end
                        default:       next_out = out_level;
                    endcase
                end
                default: next_out = out_level;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            out_level         <= 1'b0;
            timer_out_pin     <= 1'b0;
            timer_out_inv_pin <= 1'b1;
        end
        else
        begin
            out_level         <= next_out;
            timer_out_pin     <= next_out;
            timer_out_inv_pin <= !next_out;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_match_a <= 1'b0;
            irq_match_p <= 1'b0;
        end
        else
        begin
            irq_match_a <= counter_enable_bit && !pause && match_a;
            irq_match_p <= counter_enable_bit && !pause && match_p;
        end
    end

    // Sticky flags readable by software; writing a one clears, a new event wins.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            status <= 8'h0;
        else
        begin
            status[0] <= irq_match_a
                || (status[0] && !(wr_stb && addr_is(paddr, `TMC_OFF_STATUS) && pwdata[0]));
            status[1] <= irq_match_p
                || (status[1] && !(wr_stb && addr_is(paddr, `TMC_OFF_STATUS) && pwdata[1]));
            status[7:2] <= 6'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0           <= `TMC_CTRL_RESET;
            ctrl1           <= `TMC_CTRL_RESET;
            compare_a_value <= '0;
            lo_buffer       <= 8'h0;
        end
        else if (wr_stb)
        begin
            if (addr_is(paddr, `TMC_OFF_CTRL0))
                ctrl0 <= pwdata[7:0];
            if (addr_is(paddr, `TMC_OFF_CTRL1))
                ctrl1 <= pwdata[7:0];
            if (addr_is(paddr, `TMC_OFF_CMPA_LO))
                lo_buffer <= pwdata[7:0];
            if (addr_is(paddr, `TMC_OFF_CMPA_HI))
                compare_a_value <= {pwdata[HI_W-1:0], lo_buffer};
        end
        else if (rd_stb)
        begin
            if (addr_is(paddr, `TMC_OFF_CNT_HI))
                lo_buffer <= count[7:0];
            if (addr_is(paddr, `TMC_OFF_CMPA_HI))
                lo_buffer <= compare_a_value[7:0];
        end
    end

    always_comb
    begin
        next_rdata = 32'h0;
        case (paddr)
            `TMC_OFF_CTRL0:   next_rdata[7:0] = ctrl0;
            `TMC_OFF_CTRL1:   next_rdata[7:0] = ctrl1;
            `TMC_OFF_CNT_LO,
            `TMC_OFF_CMPA_LO: next_rdata[7:0] = lo_buffer;
            `TMC_OFF_CNT_HI:  next_rdata[HI_W-1:0] = count[CNT_W-1:8];
            `TMC_OFF_CMPA_HI: next_rdata[HI_W-1:0] = compare_a_value[CNT_W-1:8];
            `TMC_OFF_STATUS:  next_rdata[7:0] = status;
            default:          next_rdata = 32'h0;
        endcase
    end

    // No wait states: ready rises in the first access cycle, read data with it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= setup;
            prdata  <= setup ? next_rdata : 32'h0;
            pslverr <= setup && !mapped;
        end
    end

endmodule

//--- verif/tmc_core_monitor.sv
/* Port checker for the timer core.
   Bound to every tmc_core instance; sees only its ports. */
`timescale 1ns/1ps
module tmc_core_monitor (
    input wire logic        pclk,              // Clock.
    input wire logic        presetn,           // Reset, active low.
    input wire logic        psel,              // Select.
    input wire logic        penable,           // Access phase.
    input wire logic        pwrite,            // Write.
    input wire logic [11:0] paddr,             // Address.
    input wire logic [31:0] prdata,            // Read data.
    input wire logic        pready,            // Ready.
    input wire logic        pslverr,           // Error.
    input wire logic        timer_out_pin,     // Output pin.
    input wire logic        timer_out_inv_pin, // Inverted pin.
    input wire logic        irq_match_a,       // Match A pulse.
    input wire logic        irq_match_p        // Match P pulse.
);
    default clocking mon_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_inv_pin_mirror: assert property (timer_out_inv_pin == !timer_out_pin)
        else $error("inverted pin is not the inverse");
    a_ready_one_cycle: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("ready not a single cycle after setup");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && !penable && paddr[1:0] == 2'h0
        |=> pslverr == (paddr > 12'h018))
        else $error("error flag wrong for address");
    a_hi_byte_width: assert property (pready && !pwrite
        && (paddr == 12'h00c || paddr == 12'h014) |-> prdata[31:2] == 30'h0)
        else $error("high byte wider than two bits");
    a_lo_byte_width: assert property (pready && !pwrite
        && (paddr == 12'h008 || paddr == 12'h010) |-> prdata[31:8] == 24'h0)
        else $error("low byte wider than eight bits");
    a_rdata_idle_zero: assert property (!pready |-> prdata == 32'h0)
        else $error("read data outside ready");
    a_p_match_spacing: assert property (irq_match_p |=> !irq_match_p [*8])
        else $error("period matches too close");
    a_pin_has_cause: assert property ($changed(timer_out_pin) |-> irq_match_a
        || irq_match_p || $past(pready && pwrite) || $past(pready && pwrite, 2))
        else $error("output pin changed without cause");
endmodule

bind tmc_core tmc_core_monitor u_mon (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .timer_out_pin(timer_out_pin),
    .timer_out_inv_pin(timer_out_inv_pin), .irq_match_a(irq_match_a),
    .irq_match_p(irq_match_p));

//--- verif/tmc_pins_model.sv
/* Model of the clocks and the count pin around the timer core.
   Assumes the testbench supplies pclk and calls drive or pulse. */
`timescale 1ns/1ps
module tmc_pins_model (
    input  wire logic pclk,          // System clock.
    output logic      high_clk_tick, // High clock.
    output logic      sub_clk_tick,  // Subsidiary clock.
    output logic      ext_clock_pin  // Count pin.
);
    initial
    begin
        high_clk_tick = 1'b0;
        sub_clk_tick = 1'b0;
        ext_clock_pin = 1'b0;
    end
    always #6 high_clk_tick = !high_clk_tick;
    always #20 sub_clk_tick = !sub_clk_tick;
    // Each level is held four clocks so the pin synchroniser sees it.
    task automatic drive(input logic v);
        @(posedge pclk);
        ext_clock_pin <= v;
        repeat (4) @(posedge pclk);
    endtask
    task automatic pulse(input int n);
        repeat (n)
        begin
            drive(1'b1);
            drive(1'b0);
        end
    endtask
endmodule

//--- verif/tmc_core_test.sv
/* Self-checking testbench for the timer core.
   Drives APB and the pin model; the port checker is bound. */
`timescale 1ns/1ps
`include "tmc_params.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tmc_core_test;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, rerr, p0, hck, sck, xck;
    logic        timer_out_pin, timer_out_inv_pin, irq_match_a, irq_match_p;
    logic [9:0]  cv;
    logic [7:0]  mv [5] = '{8'h19, 8'h21, 8'h09, 8'hf1, 8'h71};
    logic [4:0]  mp = 5'b11110;
    logic [2:0]  tp [3] = '{3'h1, 3'h3, 3'h0};
    int          pg [3] = '{128, 384, 1024};
    logic [10:0] ex [6] = '{11'd64, 11'd258, 11'd5, 11'd1, 11'd25, 11'd25};
    int          errors = 0;
    int          compares = 0;
    int          n;

    always #2 pclk = !pclk;

    tmc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .high_clk_tick(hck), .sub_clk_tick(sck),
        .ext_clock_pin(xck), .timer_out_pin(timer_out_pin),
        .timer_out_inv_pin(timer_out_inv_pin), .irq_match_a(irq_match_a),
        .irq_match_p(irq_match_p));
    tmc_pins_model pins (.pclk(pclk), .high_clk_tick(hck), .sub_clk_tick(sck),
        .ext_clock_pin(xck));

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // High byte first so the low byte is latched into the shared buffer.
    task automatic rdcnt();
        logic [1:0] h;
        apb(1'b0, `TMC_OFF_CNT_HI, 32'h0);
        h = rdat[1:0];
        apb(1'b0, `TMC_OFF_CNT_LO, 32'h0);
        cv = {h, rdat[7:0]};
    endtask
    task automatic gap(input logic p);
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while ((p ? irq_match_p : irq_match_a) !== 1'b1 && n < 3000);
        if (n >= 3000)
            errors++;
    endtask
    task automatic complete_run();
        $display("compares=%0d errors=%0d", compares, errors);
        if (errors == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(`TMC_OFF_CTRL0, {24'h0, `TMC_CTRL_RESET});
        rd(`TMC_OFF_CTRL1, {24'h0, `TMC_CTRL_RESET});
        rd(12'h01c, 32'h0);
        `CHK(rerr, 1'b1)
        $display("test reset done");
        wr(`TMC_OFF_CMPA_LO, 32'h5a);
        wr(`TMC_OFF_CMPA_HI, 32'h3);
        rd(`TMC_OFF_CMPA_HI, 32'h3);
        rd(`TMC_OFF_CMPA_LO, 32'h5a);
        wr(`TMC_OFF_CMPA_LO, 32'ha5);
        rd(`TMC_OFF_CMPA_HI, 32'h3);
        rd(`TMC_OFF_CMPA_LO, 32'h5a);
        wr(`TMC_OFF_CMPA_HI, 32'hff);
        rd(`TMC_OFF_CMPA_HI, 32'h3);
        pstrb <= 4'he;
        wr(`TMC_OFF_CTRL1, 32'h55);
        pstrb <= 4'hf;
        rd(`TMC_OFF_CTRL1, {24'h0, `TMC_CTRL_RESET});
        $display("test byte pairs done");
        wr(`TMC_OFF_CMPA_LO, 32'h2);
        wr(`TMC_OFF_CMPA_HI, 32'h0);
        wr(`TMC_OFF_CTRL1, 32'h31);
        wr(`TMC_OFF_CTRL0, 32'h18);
        gap(1'b0);
        p0 = timer_out_pin;
        gap(1'b0);
        `CHK(n, 3)
        `CHK(timer_out_pin, !p0)
        rd(`TMC_OFF_STATUS, 32'h1);
        for (int k = 0; k < 5; k++)
        begin
            wr(`TMC_OFF_CTRL0, 32'h10);
            wr(`TMC_OFF_CTRL1, {24'h0, mv[k]});
            wr(`TMC_OFF_CTRL0, 32'h18);
            gap(1'b0);
            gap(1'b0);
            `CHK(timer_out_pin, mp[k])
        end
        $display("test compare modes done");
        wr(`TMC_OFF_CTRL1, 32'ha0);
        for (int k = 0; k < 3; k++)
        begin
            wr(`TMC_OFF_CTRL0, 32'h10);
            wr(`TMC_OFF_CTRL0, {24'h0, 5'h03, tp[k]});
            gap(1'b1);
            gap(1'b1);
            `CHK(n, pg[k])
        end
        `CHK(timer_out_pin, 1'b0)
        gap(1'b0);
        `CHK(timer_out_pin, 1'b1)
        $display("test pwm done");
        wr(`TMC_OFF_CTRL0, 32'h10);
        wr(`TMC_OFF_CTRL1, 32'hc0);
        wr(`TMC_OFF_CTRL0, 32'h68);
        pins.pulse(3);
        rdcnt();
        `CHK(cv, 10'd3)
        wr(`TMC_OFF_CTRL0, 32'he8);
        pins.pulse(2);
        rdcnt();
        `CHK(cv, 10'd3)
        wr(`TMC_OFF_CTRL0, 32'h60);
        pins.pulse(1);
        rdcnt();
        `CHK(cv, 10'd3)
        wr(`TMC_OFF_CTRL0, 32'h78);
        pins.drive(1'b1);
        rdcnt();
        `CHK(cv, 10'd0)
        pins.drive(1'b0);
        rdcnt();
        `CHK(cv, 10'd1)
        $display("test pin clock done");
        wr(`TMC_OFF_CTRL0, 32'h0);
        for (int k = 0; k < 6; k++)
        begin
            wr(`TMC_OFF_CTRL0, {24'h0, 1'b0, k[2:0], 4'h8});
            repeat (256) @(posedge pclk);
            wr(`TMC_OFF_CTRL0, {24'h0, 1'b0, k[2:0], 4'h0});
            rdcnt();
            `CHK(cv + 11'd4 >= ex[k] && cv <= ex[k] + 11'd4, 1'b1)
        end
        rd(`TMC_OFF_STATUS, 32'h3);
        wr(`TMC_OFF_STATUS, 32'h3);
        rd(`TMC_OFF_STATUS, 32'h0);
        $display("test clock select done");
        complete_run();
    end

    // The tests need about five thousand clocks; eight times that means a hang.
    initial
    begin
        #160000;
        errors++;
        complete_run();
    end
endmodule
